// ===== verilog/iesm_pkg.sv
// shared constants, encodings and types for the instruction executor
package iesm_pkg;
  // bus map, byte addresses of 32-bit word registers
  localparam logic [4:0] IESM_OFS_INSTR  = 5'h00; // issue opcode, read busy
  localparam logic [4:0] IESM_OFS_ACC    = 5'h04; // accumulator
  localparam logic [4:0] IESM_OFS_STATUS = 5'h08; // status flags
  localparam logic [4:0] IESM_OFS_PC     = 5'h0c; // program_counter
  localparam logic [4:0] IESM_OFS_STACK  = 5'h10; // push return address
  localparam logic [4:0] IESM_OFS_FADDR  = 5'h14; // file window address
  localparam logic [4:0] IESM_OFS_FDATA  = 5'h18; // file window data
  localparam logic [4:0] IESM_OFS_WDOG   = 5'h1c; // watchdog view, write wakes

  // sizes
  localparam int IESM_PC_W        = 13;
  localparam int IESM_STACK_DEPTH = 8;
  localparam int IESM_FILE_WORDS  = 128;
  localparam int IESM_WDOG_W      = 8;

  // status field positions
  localparam int IESM_BIT_CARRY  = 0;
  localparam int IESM_BIT_NIBBLE = 1;
  localparam int IESM_BIT_ZERO   = 2;
  localparam int IESM_BIT_PWRDN_N = 3;
  localparam int IESM_BIT_EXP_N  = 4;
  localparam int IESM_BIT_BUSY   = 0; // instr register read
  localparam int IESM_BIT_ASLEEP = 1;

  // opcode fields
  localparam int IESM_OP_HI    = 13;
  localparam int IESM_OP_LO    = 8;
  localparam int IESM_BIT_DEST = 7;

  // opcode encodings of the upper field
  localparam logic [5:0] IESM_ENC_MOVE   = 6'h01;
  localparam logic [5:0] IESM_ENC_RETURN = 6'h02;
  localparam logic [5:0] IESM_ENC_SLEEP  = 6'h03;
  localparam logic [5:0] IESM_ENC_ROT_R  = 6'h10;
  localparam logic [5:0] IESM_ENC_ROT_L  = 6'h11;
  localparam logic [5:0] IESM_ENC_RETLIT = 6'h20;
  localparam logic [5:0] IESM_ENC_SUBLIT = 6'h21;

  // values after reset
  localparam logic [7:0]  IESM_RST_ACC    = 8'h00;
  localparam logic [4:0]  IESM_RST_STATUS = 5'h18; // both low-active flags high
  localparam logic [6:0]  IESM_RST_FADDR  = 7'h00;
  localparam logic [13:0] IESM_RST_INSTR  = 14'h0000;
  localparam logic [7:0]  IESM_WDOG_CLEAR = 8'h00;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH, ST_SLEEP} iesm_state_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_MOVE_ACC_TO_FILE, OP_RETURN_WITH_LITERAL, OP_ROTATE_LEFT,
    OP_ROTATE_RIGHT, OP_SLEEP, OP_RETURN, OP_LITERAL_MINUS_ACC
  } iesm_op_t;

  // upper opcode field to operation kind, unknown codes act as no-op
  function automatic iesm_op_t iesm_decode(input logic [13:0] word);
    case (word[IESM_OP_HI:IESM_OP_LO])
      IESM_ENC_MOVE:   return OP_MOVE_ACC_TO_FILE;
      IESM_ENC_RETURN: return OP_RETURN;
      IESM_ENC_SLEEP:  return OP_SLEEP;
      IESM_ENC_ROT_R:  return OP_ROTATE_RIGHT;
      IESM_ENC_ROT_L:  return OP_ROTATE_LEFT;
      IESM_ENC_RETLIT: return OP_RETURN_WITH_LITERAL;
      IESM_ENC_SUBLIT: return OP_LITERAL_MINUS_ACC;
      default:         return OP_NONE;
    endcase
  endfunction
endpackage

// ===== verilog/iesm_alu.sv
// rotate and literal-minus-accumulator datapath with flag outputs
`timescale 1ns/10ps
module iesm_alu
  import iesm_pkg::*;
(
  input  wire iesm_op_t   op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] fdata,
  input  wire logic [7:0] lit,
  input  wire logic       carry_in,
  output logic [7:0]      result,
  output logic            carry_out,
  output logic            nibble_out,
  output logic            zero_out
);
  logic [8:0] diff; // literal plus inverted acc plus one
  logic [4:0] diff_lo; // low nibble of the same sum

  // two's complement subtract, carry out high means no borrow
  always_comb begin
    diff    = {1'b0, lit} + {1'b0, ~acc} + 9'h001;
    diff_lo = {1'b0, lit[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  end

  // result and flags per operation
  always_comb begin
    result     = fdata;
    carry_out  = carry_in;
    nibble_out = diff_lo[4];
    case (op)
      OP_ROTATE_LEFT: begin
        result    = {fdata[6:0], carry_in};
        carry_out = fdata[7];
      end
      OP_ROTATE_RIGHT: begin
        result    = {carry_in, fdata[7:1]};
        carry_out = fdata[0];
      end
      OP_LITERAL_MINUS_ACC: begin
        result    = diff[7:0];
        carry_out = diff[8];
      end
      default: begin
        result = fdata;
      end
    endcase
    zero_out = (result == 8'h00);
  end
endmodule // iesm_alu

// ===== verilog/iesm_stack.sv
// circular return-address stack, wraps silently like the hardware one
`timescale 1ns/10ps
module iesm_stack
  import iesm_pkg::*;
#(
  parameter int DEPTH = IESM_STACK_DEPTH,
  parameter int W     = IESM_PC_W
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  input  wire logic                     push,
  input  wire logic [W-1:0]             push_data,
  input  wire logic                     pop,
  output logic [W-1:0]                  stack_top,
  output logic [$clog2(DEPTH)-1:0]      stack_ptr
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH]; // return addresses
  logic [PW-1:0] top_idx;     // slot of the newest entry

  // entry one below the pointer is the newest one
  always_comb begin
    top_idx   = stack_ptr - 1'b1;
    stack_top = mem[top_idx];
  end

  // pointer, no overflow check: deep nesting overwrites oldest
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stack_ptr <= '0;
    end else if (clk_en) begin
      if (push && !pop) begin
        stack_ptr <= stack_ptr + 1'b1;
      end else if (pop && !push) begin
        stack_ptr <= stack_ptr - 1'b1;
      end
    end
  end

  // storage, no reset needed for data
  always_ff @(posedge ref_clk) begin
    if (clk_en && push && !pop) begin
      mem[stack_ptr] <= push_data;
    end
  end
endmodule // iesm_stack

// ===== verilog/iesm_core.sv
// instruction executor top: bus slave, sequencing, file space, watchdog
// Overview of operation
// - move accumulator into addressed file register
// - literal to accumulator, pop into counter, two cycles
// - rotate left through carry, only carry changes
// - rotate right through carry, only carry changes
// - destination bit picks accumulator or file
// - sleep clears powerdown flag, sets expiry flag
// - sleep clears watchdog counter and prescaler
// - sleep halts oscillator, core enters sleep
// - return pops stack into counter, two cycles
// - literal minus accumulator into accumulator, flags
`timescale 1ns/10ps
module iesm_core
  import iesm_pkg::*;
#(
  parameter int PC_W        = IESM_PC_W,
  parameter int STACK_DEPTH = IESM_STACK_DEPTH
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             osc_run
);
  localparam int SPW = $clog2(STACK_DEPTH);

  // architectural state
  iesm_state_t          state;       // sequencer
  iesm_state_t          next_state;  // sequencer next
  logic [13:0]          instr_q;     // latched opcode
  logic [7:0]           acc;         // accumulator
  logic [4:0]           status;      // flags
  logic [PC_W-1:0]      program_counter;
  logic [6:0]           faddr;       // bus window into file space
  logic [7:0]           fmem [IESM_FILE_WORDS]; // file registers
  logic [IESM_WDOG_W-1:0] watchdog_counter;
  logic [IESM_WDOG_W-1:0] wdog_prescaler;

  // decode and datapath
  iesm_op_t             op_q;        // decoded latched opcode
  logic [6:0]           f_sel;       // file operand
  logic [7:0]           lit;         // literal operand
  logic                 dest_file;   // destination bit
  logic [7:0]           fdata;       // file operand value
  logic [7:0]           alu_res;
  logic                 alu_c;
  logic                 alu_nib;
  logic                 alu_z;
  logic                 exec_fire;   // executing this edge
  logic                 is_rotate;
  logic [PC_W-1:0]      stack_top;
  logic [SPW-1:0]       stack_ptr;
  logic                 do_pop;

  // bus side
  logic                 accept;      // request may be answered now
  logic                 bus_wr;      // write takes effect this edge
  logic [31:0]          rd_mux;      // read data source
  logic [31:0]          wr_merged;   // write data after byte lanes

  // address match, used by every register
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    return a == ofs;
  endfunction

  // lanes without byte enable keep the old value
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // operand fields
  always_comb begin
    op_q      = iesm_decode(instr_q);
    f_sel     = instr_q[6:0];
    lit       = instr_q[7:0];
    dest_file = instr_q[IESM_BIT_DEST];
    fdata     = fmem[f_sel];
    exec_fire = clk_en && (state == ST_EXEC);
    is_rotate = (op_q == OP_ROTATE_LEFT) || (op_q == OP_ROTATE_RIGHT);
    do_pop    = exec_fire && ((op_q == OP_RETURN) || (op_q == OP_RETURN_WITH_LITERAL));
  end

  iesm_alu u_alu (
    .op         (op_q),
    .acc        (acc),
    .fdata      (fdata),
    .lit        (lit),
    .carry_in   (status[IESM_BIT_CARRY]),
    .result     (alu_res),
    .carry_out  (alu_c),
    .nibble_out (alu_nib),
    .zero_out   (alu_z)
  );

  iesm_stack #(
    .DEPTH (STACK_DEPTH),
    .W     (PC_W)
  ) u_stack (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .push      (bus_wr && hit(avs_address, IESM_OFS_STACK)),
    .push_data (avs_writedata[PC_W-1:0]),
    .pop       (do_pop),
    .stack_top (stack_top),
    .stack_ptr (stack_ptr)
  );

  // writes wait while an instruction runs, wake register never waits
  assign accept = !avs_write || (state == ST_IDLE) || hit(avs_address, IESM_OFS_WDOG);
  assign bus_wr = clk_en && avs_write && !avs_waitrequest;

  // read mux, unmapped addresses read zero
  always_comb begin
    case (avs_address)
      IESM_OFS_INSTR:  rd_mux = {30'h0000_0000, state == ST_SLEEP, state != ST_IDLE};
      IESM_OFS_ACC:    rd_mux = {24'h00_0000, acc};
      IESM_OFS_STATUS: rd_mux = {27'h000_0000, status};
      IESM_OFS_PC:     rd_mux = 32'(program_counter);
      IESM_OFS_STACK:  rd_mux = 32'(stack_ptr);
      IESM_OFS_FADDR:  rd_mux = {25'h000_0000, faddr};
      IESM_OFS_FDATA:  rd_mux = {24'h00_0000, fmem[faddr]};
      IESM_OFS_WDOG:   rd_mux = {16'h0000, wdog_prescaler, watchdog_counter};
      default:         rd_mux = 32'h0000_0000;
    endcase
    wr_merged = be_merge(rd_mux, avs_writedata, avs_byteenable);
  end

  // answer: one wait cycle, then a single low cycle of waitrequest
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (clk_en) begin
      if ((avs_read || avs_write) && avs_waitrequest && accept) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (bus_wr && hit(avs_address, IESM_OFS_INSTR)) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        case (op_q)
          OP_RETURN, OP_RETURN_WITH_LITERAL: next_state = ST_FLUSH;
          OP_SLEEP: next_state = ST_SLEEP;
          default:  next_state = ST_IDLE;
        endcase
      end
      ST_FLUSH: next_state = ST_IDLE; // second cycle of a return, refetch slot
      ST_SLEEP: begin // only a write to the watchdog register wakes the core
        if (bus_wr && hit(avs_address, IESM_OFS_WDOG)) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // sequencer and oscillator run flag
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state   <= ST_IDLE;
      osc_run <= 1'b1;
    end else if (clk_en) begin
      state   <= next_state;
      osc_run <= (next_state != ST_SLEEP);
    end
  end

  // opcode latch
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      instr_q <= IESM_RST_INSTR;
    end else if (bus_wr && hit(avs_address, IESM_OFS_INSTR)) begin
      instr_q <= wr_merged[13:0];
    end
  end

  // accumulator
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc <= IESM_RST_ACC;
    end else if (bus_wr && hit(avs_address, IESM_OFS_ACC)) begin
      acc <= wr_merged[7:0];
    end else if (exec_fire) begin
      if (op_q == OP_RETURN_WITH_LITERAL) begin
        acc <= lit;
      end else if ((is_rotate && !dest_file) || (op_q == OP_LITERAL_MINUS_ACC)) begin
        acc <= alu_res;
      end
    end
  end

  // status flags, the two low-active ones are read-only to software
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status <= IESM_RST_STATUS;
    end else if (bus_wr && hit(avs_address, IESM_OFS_STATUS)) begin
      status[IESM_BIT_ZERO:IESM_BIT_CARRY] <= wr_merged[IESM_BIT_ZERO:IESM_BIT_CARRY];
    end else if (exec_fire) begin
      case (op_q)
        OP_ROTATE_LEFT, OP_ROTATE_RIGHT: begin
          status[IESM_BIT_CARRY] <= alu_c;
        end
        OP_LITERAL_MINUS_ACC: begin
          status[IESM_BIT_CARRY]  <= alu_c;
          status[IESM_BIT_NIBBLE] <= alu_nib;
          status[IESM_BIT_ZERO]   <= alu_z;
        end
        OP_SLEEP: begin
          status[IESM_BIT_PWRDN_N] <= 1'b0;
          status[IESM_BIT_EXP_N] <= 1'b1;
        end
        default: status <= status; // moves and returns leave every flag alone
      endcase
    end
  end

  // program counter, returns reload from the stack
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      program_counter <= '0;
    end else if (bus_wr && hit(avs_address, IESM_OFS_PC)) begin
      program_counter <= wr_merged[PC_W-1:0];
    end else if (exec_fire) begin
      if (do_pop) begin
        program_counter <= stack_top;
      end else begin
        program_counter <= program_counter + 1'b1;
      end
    end
  end

  // file window address
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      faddr <= IESM_RST_FADDR;
    end else if (bus_wr && hit(avs_address, IESM_OFS_FADDR)) begin
      faddr <= wr_merged[6:0];
    end
  end

  // file space, bus writes and instruction writes never meet
  always_ff @(posedge ref_clk) begin
    if (bus_wr && hit(avs_address, IESM_OFS_FDATA)) begin
      fmem[faddr] <= wr_merged[7:0];
    end else if (exec_fire) begin
      if (op_q == OP_MOVE_ACC_TO_FILE) begin
        fmem[f_sel] <= acc;
      end else if (is_rotate && dest_file) begin
        fmem[f_sel] <= alu_res;
      end
    end
  end

  // watchdog keeps counting in sleep, osc_run does not gate it, only clk_en
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      watchdog_counter <= IESM_WDOG_CLEAR;
      wdog_prescaler   <= IESM_WDOG_CLEAR;
    end else if (exec_fire && (op_q == OP_SLEEP)) begin
      watchdog_counter <= IESM_WDOG_CLEAR;
      wdog_prescaler   <= IESM_WDOG_CLEAR;
    end else if (clk_en) begin
      wdog_prescaler <= wdog_prescaler + 1'b1;
      if (&wdog_prescaler) begin
        watchdog_counter <= watchdog_counter + 1'b1;
      end
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // operand slices as whole signals, so the history functions see plain names
  wire logic       fdata_msb = fdata[7];
  wire logic       fdata_lsb = fdata[0];
  wire logic [3:0] lit_lo    = lit[3:0];
  wire logic [3:0] acc_lo    = acc[3:0];

  sequence seq_return_issue;
    exec_fire && (op_q == OP_RETURN);
  endsequence
  sequence seq_retlit_issue;
    exec_fire && (op_q == OP_RETURN_WITH_LITERAL);
  endsequence
  sequence seq_sleep_issue;
    exec_fire && (op_q == OP_SLEEP);
  endsequence

  chk_move_store: assert property (
    exec_fire && (op_q == OP_MOVE_ACC_TO_FILE) |=>
      (fmem[$past(f_sel)] == $past(acc)) && (status == $past(status)))
    else $error("move did not store accumulator");
  chk_retlit_load: assert property (
    seq_retlit_issue |=> (acc == $past(lit)) && (program_counter == $past(stack_top))
      && (status == $past(status)) ##0 (state == ST_FLUSH))
    else $error("literal return wrong");
  chk_rotl_carry: assert property (
    exec_fire && (op_q == OP_ROTATE_LEFT) |->
      (alu_res == {fdata[6:0], status[IESM_BIT_CARRY]})
      ##1 (status[IESM_BIT_CARRY] == $past(fdata_msb))
      && (status[4:1] == $past(status[4:1])))
    else $error("rotate left wrong");
  chk_rotr_carry: assert property (
    exec_fire && (op_q == OP_ROTATE_RIGHT) |->
      (alu_res == {status[IESM_BIT_CARRY], fdata[7:1]})
      ##1 (status[IESM_BIT_CARRY] == $past(fdata_lsb))
      && (status[4:1] == $past(status[4:1])))
    else $error("rotate right wrong");
  chk_rot_dest: assert property (
    exec_fire && is_rotate |=> dest_file ?
      ((fmem[$past(f_sel)] == $past(alu_res)) && (acc == $past(acc))) :
      (acc == $past(alu_res)))
    else $error("rotate destination wrong");
  chk_sleep_flags: assert property (
    seq_sleep_issue |=> !status[IESM_BIT_PWRDN_N] && status[IESM_BIT_EXP_N]
      && (status[2:0] == $past(status[2:0])))
    else $error("sleep flags wrong");
  chk_sleep_wdog: assert property (
    seq_sleep_issue |=> (watchdog_counter == 8'h00) && (wdog_prescaler == 8'h00))
    else $error("sleep did not clear watchdog");
  chk_sleep_osc: assert property (
    seq_sleep_issue |=> (state == ST_SLEEP) && !osc_run)
    else $error("sleep did not halt oscillator");
  chk_return_pop: assert property (
    seq_return_issue |=> (program_counter == $past(stack_top))
      && (status == $past(status)) && (state == ST_FLUSH))
    else $error("return did not pop");
  chk_sub_result: assert property (
    exec_fire && (op_q == OP_LITERAL_MINUS_ACC) |=>
      (acc == 8'($past(lit) - $past(acc))) && (status[IESM_BIT_ZERO] == (acc == 8'h00)))
    else $error("subtract result wrong");
  chk_sub_borrow: assert property (
    exec_fire && (op_q == OP_LITERAL_MINUS_ACC) |=>
      (status[IESM_BIT_CARRY] == ($past(lit) >= $past(acc)))
      && (status[IESM_BIT_NIBBLE] == ($past(lit_lo) >= $past(acc_lo))))
    else $error("subtract borrow flags wrong");
endmodule // iesm_core

// ===== verification/testbench.sv
// self-checking bench for the instruction executor over its register bus
`timescale 1ns/10ps
module testbench;
  import iesm_pkg::*;

  logic        ref_clk;         // 20 MHz core clock
  logic        rst_n;           // synchronous reset, low active
  logic        clk_en;          // high except in the freeze scenario
  logic [4:0]  avs_address;     // bus byte address
  logic        avs_read;        // bus read strobe
  logic        avs_write;       // bus write strobe
  logic [31:0] avs_writedata;   // bus write data
  logic [3:0]  avs_byteenable;  // all lanes on
  logic [31:0] avs_readdata;    // bus read data
  logic        avs_waitrequest; // low for one cycle = answer
  logic        osc_run;         // low while asleep
  int          num_errors;      // mismatches seen
  int          check_count;     // comparisons made
  int          seed;            // fixed random seed
  logic [12:0] pc_exp;          // modelled program counter
  logic [1:0]  st_hi;           // modelled expiry and powerdown bits
  logic [31:0] rd;              // last read word

  iesm_core iesm_core_inst (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .clk_en         (clk_en),
    .avs_address    (avs_address),
    .avs_read       (avs_read),
    .avs_write      (avs_write),
    .avs_writedata  (avs_writedata),
    .avs_byteenable (avs_byteenable),
    .avs_readdata   (avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .osc_run        (osc_run)
  );

  // free-running clock, 50 ns period
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // verdict and end of run, the only exit
  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one comparison, mismatches reported at once
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one bus cycle; request held until waitrequest is sampled low
  task automatic bus_cycle(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 400);
    rd = avs_readdata; // taken at the answer edge only
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      num_errors++;
      wrap_up();
    end
  endtask

  // expected {flags low, acc, file} after one operation
  function automatic logic [18:0] expect_op(input logic [5:0] enc, input logic [7:0] a,
      input logic [7:0] v, input logic [7:0] k, input logic [2:0] s3, input logic dst);
    logic [7:0] r;
    logic [7:0] e_acc;
    logic [7:0] e_file;
    logic [2:0] e_lo;
    e_acc  = a;
    e_file = v;
    e_lo   = s3;
    r      = (enc == IESM_ENC_ROT_L) ? {v[6:0], s3[0]} : {s3[0], v[7:1]};
    case (enc)
      IESM_ENC_MOVE: e_file = a;
      IESM_ENC_ROT_L, IESM_ENC_ROT_R: begin
        // only carry moves, the other flags stay
        e_lo[0] = (enc == IESM_ENC_ROT_L) ? v[7] : v[0];
        if (dst) begin
          e_file = r;
        end else begin
          e_acc = r;
        end
      end
      IESM_ENC_SUBLIT: begin
        // carry and nibble flag mean no borrow
        e_acc = k - a;
        e_lo  = {e_acc == 8'h00, k[3:0] >= a[3:0], k >= a};
      end
      IESM_ENC_RETLIT: e_acc = k;
      default: e_acc = a; // return, no-op: nothing but the counter
    endcase
    return {e_lo, e_acc, e_file};
  endfunction

  // load operands, issue one opcode, read back everything it may touch
  task automatic exec(input logic [5:0] enc, input logic [7:0] a, input logic [7:0] v,
      input logic [7:0] k, input logic [2:0] s3, input logic dst, input logic [6:0] f);
    logic [18:0] e;
    logic [12:0] ret;
    logic        is_ret;
    e      = expect_op(enc, a, v, k, s3, dst);
    ret    = 13'($random(seed));
    is_ret = (enc == IESM_ENC_RETLIT || enc == IESM_ENC_RETURN);
    bus_cycle(1'b1, IESM_OFS_ACC, 32'(a));
    bus_cycle(1'b1, IESM_OFS_STATUS, 32'(s3));
    bus_cycle(1'b1, IESM_OFS_FADDR, 32'(f));
    bus_cycle(1'b1, IESM_OFS_FDATA, 32'(v));
    if (is_ret) begin
      bus_cycle(1'b1, IESM_OFS_STACK, 32'(ret));
    end
    // literal ops carry k in the low byte, others dest and address
    if (enc == IESM_ENC_RETLIT || enc == IESM_ENC_SUBLIT) begin
      bus_cycle(1'b1, IESM_OFS_INSTR, 32'({enc, k}));
    end else begin
      bus_cycle(1'b1, IESM_OFS_INSTR, 32'({enc, dst, f}));
    end
    pc_exp = is_ret ? ret : pc_exp + 13'h0001;
    bus_cycle(1'b0, IESM_OFS_ACC, 32'h0000_0000);
    check("acc", rd[7:0], e[15:8]);
    bus_cycle(1'b0, IESM_OFS_STATUS, 32'h0000_0000);
    check("status", rd[4:0], {st_hi, e[18:16]});
    bus_cycle(1'b0, IESM_OFS_FDATA, 32'h0000_0000);
    check("file", rd[7:0], e[7:0]);
    bus_cycle(1'b0, IESM_OFS_PC, 32'h0000_0000);
    check("pc", rd[12:0], pc_exp);
  endtask

  // main sequence: reset, corner cases, random mix, sleep and wake
  initial begin
    logic [5:0] encs [7];
    int         i;
    logic [7:0] pre_seen;
    encs = '{IESM_ENC_MOVE, IESM_ENC_ROT_L, IESM_ENC_ROT_R, IESM_ENC_SUBLIT,
             IESM_ENC_RETLIT, IESM_ENC_RETURN, 6'h3f};
    seed = 15;
    num_errors = 0;
    check_count = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    pc_exp = 13'h0000;
    st_hi = 2'b11;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus_cycle(1'b0, IESM_OFS_STATUS, 32'h0000_0000);
    check("status after reset", rd[4:0], 5'h18);
    check("osc after reset", osc_run, 1'b1);
    // corner cases: top and bottom address, edge bits, borrows
    exec(IESM_ENC_MOVE, 8'h5a, 8'h00, 8'h00, 3'h7, 1'b0, 7'h7f);
    exec(IESM_ENC_ROT_L, 8'h11, 8'h80, 8'h00, 3'h6, 1'b1, 7'h00);
    exec(IESM_ENC_ROT_R, 8'h22, 8'h01, 8'h00, 3'h1, 1'b0, 7'h7f);
    exec(IESM_ENC_SUBLIT, 8'h3c, 8'h00, 8'h3c, 3'h0, 1'b0, 7'h01);
    exec(IESM_ENC_SUBLIT, 8'h01, 8'h00, 8'h00, 3'h7, 1'b0, 7'h02);
    exec(IESM_ENC_SUBLIT, 8'h01, 8'h00, 8'h10, 3'h0, 1'b0, 7'h03);
    exec(IESM_ENC_SUBLIT, 8'h00, 8'h00, 8'hff, 3'h0, 1'b0, 7'h04);
    // random mix over every opcode except sleep, unknown one included
    for (i = 0; i < 60; i++) begin
      exec(encs[($random(seed) & 32'h7fff_ffff) % 7], 8'($random(seed)),
           8'($random(seed)), 8'($random(seed)), 3'($random(seed)),
           1'($random(seed)), 7'($random(seed)));
    end
    // let the watchdog run so that clearing is visible
    repeat (600) @(posedge ref_clk);
    // a low enable must freeze the free-running prescaler
    bus_cycle(1'b0, IESM_OFS_WDOG, 32'h0000_0000);
    pre_seen = rd[15:8];
    clk_en <= 1'b0;
    repeat (100) @(posedge ref_clk);
    clk_en <= 1'b1;
    bus_cycle(1'b0, IESM_OFS_WDOG, 32'h0000_0000);
    check("prescaler frozen", rd[15:8], 8'(pre_seen + 8'h03));
    bus_cycle(1'b1, IESM_OFS_STATUS, 32'h0000_0005);
    bus_cycle(1'b1, IESM_OFS_INSTR, 32'({IESM_ENC_SLEEP, 8'h00}));
    pc_exp = pc_exp + 13'h0001;
    st_hi = 2'b10;
    bus_cycle(1'b0, IESM_OFS_WDOG, 32'h0000_0000);
    check("watchdog cleared", {rd[7:0] === 8'h00, rd[15:8] < 8'h10}, 2'b11);
    bus_cycle(1'b0, IESM_OFS_STATUS, 32'h0000_0000);
    check("status asleep", rd[4:0], 5'h15);
    bus_cycle(1'b0, IESM_OFS_INSTR, 32'h0000_0000);
    check("asleep bit", rd[IESM_BIT_ASLEEP], 1'b1);
    check("osc halted", osc_run, 1'b0);
    // wake, then the core must execute again
    bus_cycle(1'b1, IESM_OFS_WDOG, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    check("osc after wake", osc_run, 1'b1);
    exec(IESM_ENC_ROT_L, 8'h0f, 8'hc3, 8'h00, 3'h2, 1'b1, 7'h40);
    wrap_up();
  end
endmodule // testbench
